// File: core/fdm_monitor.sv
// Frequency level monitor with run protection, jog, ramp and droop aids.
`timescale 1ns/10ps
// What this block does
// - Power-on hours at or past their arrival setting raise function 24.
// - Running hours at or past their arrival setting raise function 12.
// - With protection on, a run held at power-up is ignored until removed.
// - With protection on, a run held at fault reset is ignored until removed.
// - With protection off, a run held at power-up is accepted; default on.
// - Detector one flags function 3 when frequency is at or above its level.
// - A set detector flag clears only below level minus its hysteresis.
// - Function 4 while running frequency is within reach width of target.
// - With jump-during-ramp on, ramp frequency skips across jump band edges.
// - Accelerating below the accel switch point uses time 2, else time 1.
// - Decelerating at or above the decel switch point uses time 1, else time 2.
// - With jog priority on, terminal jog during running takes over.
// - Detector two behaves like detector one with its own settings.
// - Droop lowers output frequency in proportion to load.
// - Arbitrary detectors flag functions 26 and 27 within their windows.
module fdm_monitor #(
  parameter longint HOUR_CYCLES = fdm_pkg::HOUR_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] run_freq,
  input wire logic [15:0] target_freq,
  input wire logic [15:0] ramp_freq,
  input wire logic ramp_accel,
  input wire logic ramp_decel,
  input wire logic running,
  input wire logic [10:0] load_pct,
  input wire logic fault_reset,
  input wire logic run_cmd_pin,
  input wire logic jog_cmd_pin,
  output logic out_fn3_level_one,
  output logic level_two_flag,
  output logic out_fn4_reach,
  output logic out_fn12_run_time,
  output logic out_fn24_power_on,
  output logic out_fn26_arb_one,
  output logic out_fn27_arb_two,
  output logic run_allow,
  output logic jog_run,
  output logic accel_sel2,
  output logic decel_sel2,
  output logic [15:0] drive_freq,
  output logic irq
);
  logic [31:0] regs_q [fdm_pkg::NUM_RW];
  logic [31:0] regs_d [fdm_pkg::NUM_RW];
  logic [5:0] irq_stat_q;
  logic [5:0] irq_stat_d;
  logic [5:0] irq_mask_q;
  logic [5:0] irq_mask_d;
  logic [5:0] evt;
  logic bvalid_q;
  logic bvalid_d;
  logic [1:0] bresp_q;
  logic [1:0] bresp_d;
  logic rvalid_q;
  logic rvalid_d;
  logic [1:0] rresp_q;
  logic [1:0] rresp_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic wr_go;
  logic [3:0] widx;
  logic [3:0] ridx;

  // Each request is taken whole: address and data must both be offered.
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = !rvalid_q;
  assign widx = s_axi_awaddr[5:2];
  assign ridx = s_axi_araddr[5:2];

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      old[i*8 +: 8] = strb[i] ? data[i*8 +: 8] : old[i*8 +: 8];
    end
    merge = old;
  endfunction

  logic [31:0] ctrl;
  logic [15:0] pon_hours_q;
  logic [15:0] pon_hours_d;
  logic [15:0] run_hours_q;
  logic [15:0] run_hours_d;
  logic [39:0] pon_pre_q;
  logic [39:0] pon_pre_d;
  logic [39:0] run_pre_q;
  logic [39:0] run_pre_d;
  logic [31:0] status;

  assign ctrl = regs_q[0];

  always_comb begin
    for (int i = 0; i < fdm_pkg::NUM_RW; i++) begin
      regs_d[i] = regs_q[i];
    end
    irq_mask_d = irq_mask_q;
    irq_stat_d = irq_stat_q;
    bvalid_d = bvalid_q && !s_axi_bready;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q && !s_axi_rready;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (wr_go) begin
      bvalid_d = 1'b1;
      bresp_d = fdm_pkg::RESP_OKAY;
      if (s_axi_awaddr[1:0] != 2'h0 || s_axi_awaddr[7:6] != 2'h0) begin
        bresp_d = fdm_pkg::RESP_SLVERR;
      end else if (widx < 4'(fdm_pkg::NUM_RW)) begin
        regs_d[widx] = merge(regs_q[widx], s_axi_wdata, s_axi_wstrb);
      end else if (s_axi_awaddr == fdm_pkg::OFF_IRQ_STAT) begin
        if (s_axi_wstrb[0]) begin
          irq_stat_d = irq_stat_q & ~s_axi_wdata[5:0];
        end
      end else if (s_axi_awaddr == fdm_pkg::OFF_IRQ_MASK) begin
        if (s_axi_wstrb[0]) begin
          irq_mask_d = s_axi_wdata[5:0];
        end
      end else if (s_axi_awaddr != fdm_pkg::OFF_HOURS &&
                   s_axi_awaddr != fdm_pkg::OFF_STATUS) begin
        bresp_d = fdm_pkg::RESP_SLVERR;
      end
    end
    // A new event wins over a clear in the same cycle.
    irq_stat_d = irq_stat_d | evt;
    if (s_axi_arvalid && !rvalid_q) begin
      rvalid_d = 1'b1;
      rresp_d = fdm_pkg::RESP_OKAY;
      rdata_d = 32'h0000_0000;
      if (s_axi_araddr[1:0] != 2'h0 || s_axi_araddr[7:6] != 2'h0) begin
        rresp_d = fdm_pkg::RESP_SLVERR;
      end else if (ridx < 4'(fdm_pkg::NUM_RW)) begin
        rdata_d = regs_q[ridx];
      end else begin
        case (s_axi_araddr)
          fdm_pkg::OFF_HOURS: rdata_d = {run_hours_q, pon_hours_q};
          fdm_pkg::OFF_STATUS: rdata_d = status;
          fdm_pkg::OFF_IRQ_STAT: rdata_d = {26'h0000000, irq_stat_q};
          fdm_pkg::OFF_IRQ_MASK: rdata_d = {26'h0000000, irq_mask_q};
          default: rresp_d = fdm_pkg::RESP_SLVERR;
        endcase
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      regs_q[0] <= fdm_pkg::RST_CTRL;
      regs_q[1] <= fdm_pkg::RST_LVL;
      regs_q[2] <= fdm_pkg::RST_LVL;
      regs_q[3] <= fdm_pkg::RST_REACH;
      regs_q[4] <= fdm_pkg::RST_ARB;
      regs_q[5] <= fdm_pkg::RST_ARB;
      regs_q[6] <= fdm_pkg::RST_JUMP;
      regs_q[7] <= fdm_pkg::RST_JAMP;
      regs_q[8] <= fdm_pkg::RST_SWPT;
      regs_q[9] <= fdm_pkg::RST_ARRIVE;
      irq_stat_q <= 6'h00;
      irq_mask_q <= 6'h00;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      rvalid_q <= 1'b0;
      rresp_q <= 2'h0;
      rdata_q <= 32'h0000_0000;
    end else begin
      regs_q <= regs_d;
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign irq = |(irq_stat_q & irq_mask_q);

  // Hour counters saturate rather than wrap, so arrival cannot drop out.
  always_comb begin
    pon_pre_d = pon_pre_q + 40'h00_0000_0001;
    pon_hours_d = pon_hours_q;
    if (pon_pre_q >= 40'(HOUR_CYCLES - 1)) begin
      pon_pre_d = 40'h00_0000_0000;
      if (pon_hours_q != fdm_pkg::HOURS_MAX) begin
        pon_hours_d = pon_hours_q + 16'h0001;
      end
    end
    run_pre_d = run_pre_q;
    run_hours_d = run_hours_q;
    if (running) begin
      run_pre_d = run_pre_q + 40'h00_0000_0001;
      if (run_pre_q >= 40'(HOUR_CYCLES - 1)) begin
        run_pre_d = 40'h00_0000_0000;
        if (run_hours_q != fdm_pkg::HOURS_MAX) begin
          run_hours_d = run_hours_q + 16'h0001;
        end
      end
    end
  end

  logic fn24_q;
  logic fn12_q;
  logic [1:0] run_sync_q;
  logic [1:0] jog_sync_q;
  logic [1:0] settle_q;
  logic [1:0] settle_d;
  logic block_q;
  logic block_d;
  fdm_pkg::fdm_mode_t mode_q;
  fdm_pkg::fdm_mode_t mode_d;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pon_pre_q <= 40'h00_0000_0000;
      run_pre_q <= 40'h00_0000_0000;
      pon_hours_q <= 16'h0000;
      run_hours_q <= 16'h0000;
      fn24_q <= 1'b0;
      fn12_q <= 1'b0;
      run_sync_q <= 2'h0;
      jog_sync_q <= 2'h0;
      settle_q <= 2'h0;
      block_q <= 1'b1;
      mode_q <= fdm_pkg::FDM_IDLE;
    end else begin
      pon_pre_q <= pon_pre_d;
      run_pre_q <= run_pre_d;
      pon_hours_q <= pon_hours_d;
      run_hours_q <= run_hours_d;
      fn24_q <= (pon_hours_q >= regs_q[9][15:0]);
      fn12_q <= (run_hours_q >= regs_q[9][31:16]);
      run_sync_q <= {run_sync_q[0], run_cmd_pin};
      jog_sync_q <= {jog_sync_q[0], jog_cmd_pin};
      settle_q <= settle_d;
      block_q <= block_d;
      mode_q <= mode_d;
    end
  end

  // The block is held until the pin synchroniser holds a real sample.
  always_comb begin
    settle_d = (settle_q == 2'(fdm_pkg::SYNC_SETTLE)) ? settle_q
             : settle_q + 2'h1;
    block_d = block_q;
    if (!ctrl[fdm_pkg::CTRL_PROT]) begin
      block_d = 1'b0;
    end else if (fault_reset && run_sync_q[1]) begin
      block_d = 1'b1;
    end else if (settle_q == 2'(fdm_pkg::SYNC_SETTLE) && !run_sync_q[1]) begin
      block_d = 1'b0;
    end
    mode_d = mode_q;
    case (mode_q)
      fdm_pkg::FDM_IDLE: begin
        if (jog_sync_q[1]) begin
          mode_d = fdm_pkg::FDM_JOG;
        end else if (run_sync_q[1] && !block_q) begin
          mode_d = fdm_pkg::FDM_RUN;
        end
      end
      fdm_pkg::FDM_RUN: begin
        if (jog_sync_q[1] && ctrl[fdm_pkg::CTRL_JOG_PRIO]) begin
          mode_d = fdm_pkg::FDM_JOG;
        end else if (!run_sync_q[1] || block_q) begin
          mode_d = fdm_pkg::FDM_IDLE;
        end
      end
      fdm_pkg::FDM_JOG: begin
        if (!jog_sync_q[1]) begin
          mode_d = fdm_pkg::FDM_HOLD;
        end
      end
      fdm_pkg::FDM_HOLD: mode_d = fdm_pkg::FDM_IDLE;
      default: mode_d = fdm_pkg::FDM_IDLE;
    endcase
  end

  assign run_allow = (mode_q == fdm_pkg::FDM_RUN);
  assign jog_run = (mode_q == fdm_pkg::FDM_JOG);
  assign out_fn24_power_on = fn24_q;
  assign out_fn12_run_time = fn12_q;

  fdm_level_det u_level_one (
    .aclk(aclk),
    .aresetn(aresetn),
    .freq(run_freq),
    .level(regs_q[1][15:0]),
    .hyst(regs_q[1][25:16]),
    .flag(out_fn3_level_one)
  );

  fdm_level_det u_level_two (
    .aclk(aclk),
    .aresetn(aresetn),
    .freq(run_freq),
    .level(regs_q[2][15:0]),
    .hyst(regs_q[2][25:16]),
    .flag(level_two_flag)
  );

  fdm_window_det u_reach (
    .aclk(aclk),
    .aresetn(aresetn),
    .freq(run_freq),
    .center(target_freq),
    .fmax(regs_q[3][15:0]),
    .width(regs_q[3][25:16]),
    .flag(out_fn4_reach)
  );

  fdm_window_det u_arb_one (
    .aclk(aclk),
    .aresetn(aresetn),
    .freq(run_freq),
    .center(regs_q[4][15:0]),
    .fmax(regs_q[3][15:0]),
    .width(regs_q[4][25:16]),
    .flag(out_fn26_arb_one)
  );

  fdm_window_det u_arb_two (
    .aclk(aclk),
    .aresetn(aresetn),
    .freq(run_freq),
    .center(regs_q[5][15:0]),
    .fmax(regs_q[3][15:0]),
    .width(regs_q[5][25:16]),
    .flag(out_fn27_arb_two)
  );

  logic [5:0] flags_q;
  logic [15:0] skip_f;
  logic [15:0] drop;
  logic [15:0] drive_d;
  logic [15:0] drive_q;
  logic sel_a_q;
  logic sel_d_q;

  assign evt = {block_q && run_sync_q[1], fn12_q, fn24_q, out_fn4_reach,
                level_two_flag, out_fn3_level_one} & ~flags_q;
  assign status = {26'h0, jog_run, run_allow, level_two_flag,
                   out_fn27_arb_two, out_fn26_arb_one, block_q};

  always_comb begin
    skip_f = ramp_freq;
    if (ctrl[fdm_pkg::CTRL_JUMP_RAMP] && (ramp_accel || ramp_decel)) begin
      skip_f = fdm_pkg::jump_skip(ramp_freq, regs_q[6][15:0],
                                  regs_q[7][15:0]);
      skip_f = fdm_pkg::jump_skip(skip_f, regs_q[6][31:16],
                                  regs_q[7][15:0]);
    end
    drop = fdm_pkg::pct_of(regs_q[7][31:16], load_pct);
    drive_d = (skip_f > drop) ? skip_f - drop : 16'h0000;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_q <= 6'h00;
      drive_q <= 16'h0000;
      sel_a_q <= 1'b0;
      sel_d_q <= 1'b0;
    end else begin
      flags_q <= evt | (flags_q & {block_q && run_sync_q[1], fn12_q, fn24_q,
                 out_fn4_reach, level_two_flag, out_fn3_level_one});
      drive_q <= drive_d;
      sel_a_q <= ramp_accel && (run_freq < regs_q[8][15:0]);
      sel_d_q <= ramp_decel && (run_freq < regs_q[8][31:16]);
    end
  end

  assign drive_freq = drive_q;
  assign accel_sel2 = sel_a_q;
  assign decel_sel2 = sel_d_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_block_release: assert property (block_q && ctrl[0] && !fault_reset &&
    settle_q == 2'h3 && !run_sync_q[1] |=> !block_q)
    else $error("protection not released after command removal");
  a_fault_block: assert property (ctrl[0] && fault_reset && run_sync_q[1]
    |=> block_q ##1 !run_allow)
    else $error("run accepted at fault reset");
  a_prot_off: assert property (!ctrl[0] |=> !block_q)
    else $error("protection held while disabled");
  a_jog_prio: assert property (run_allow && jog_sync_q[1] && ctrl[2]
    |=> jog_run)
    else $error("jog did not take over running");
  a_accel_sel: assert property (ramp_accel && run_freq < regs_q[8][15:0]
    |=> accel_sel2)
    else $error("accel time 2 not chosen");
  a_decel_sel: assert property (ramp_decel && run_freq > regs_q[8][31:16]
    |=> !decel_sel2)
    else $error("decel time 2 chosen above switch point");
  a_power_arrive: assert property (pon_hours_q >= regs_q[9][15:0]
    |=> out_fn24_power_on)
    else $error("power-on arrival flag missing");
  a_run_arrive: assert property (run_hours_q < regs_q[9][31:16] &&
    $stable(regs_q[9]) |=> !out_fn12_run_time)
    else $error("run arrival flag early");
  a_droop_lower: assert property (drive_freq <= $past(skip_f))
    else $error("droop raised output frequency");
endmodule

// File: core/fdm_pkg.sv
// Shared constants and helper functions of the frequency level monitor.
package fdm_pkg;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_LVL1 = 8'h04;
  localparam logic [7:0] OFF_LVL2 = 8'h08;
  localparam logic [7:0] OFF_REACH = 8'h0c;
  localparam logic [7:0] OFF_ARB1 = 8'h10;
  localparam logic [7:0] OFF_ARB2 = 8'h14;
  localparam logic [7:0] OFF_JUMP = 8'h18;
  localparam logic [7:0] OFF_JAMP = 8'h1c;
  localparam logic [7:0] OFF_SWPT = 8'h20;
  localparam logic [7:0] OFF_ARRIVE = 8'h24;
  localparam logic [7:0] OFF_HOURS = 8'h28;
  localparam logic [7:0] OFF_STATUS = 8'h2c;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h30;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h34;
  localparam int NUM_RW = 10;
  localparam int NUM_EVT = 6;
  // Control bit positions.
  localparam int CTRL_PROT = 0;
  localparam int CTRL_JUMP_RAMP = 1;
  localparam int CTRL_JOG_PRIO = 2;
  // Frequencies in 0.01 Hz, percentages in 0.1 percent.
  localparam logic [31:0] RST_CTRL = 32'h0000_0001;
  localparam logic [31:0] RST_LVL = 32'h0032_1388;
  localparam logic [31:0] RST_REACH = 32'h0000_1388;
  localparam logic [31:0] RST_ARB = 32'h0000_1388;
  localparam logic [31:0] RST_JUMP = 32'h0000_0000;
  localparam logic [31:0] RST_JAMP = 32'h0000_0001;
  localparam logic [31:0] RST_SWPT = 32'h0000_0000;
  localparam logic [31:0] RST_ARRIVE = 32'h0000_0000;
  localparam logic [15:0] HOURS_MAX = 16'hffff;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int SYNC_SETTLE = 3;
  localparam longint CLK_HZ = 250000000;
  localparam longint HOUR_S = 3600;
  localparam longint HOUR_CYCLES = CLK_HZ * HOUR_S;
  localparam logic [26:0] PCT_FULL = 27'h00003e8;

  typedef enum logic [1:0] {
    FDM_IDLE = 2'b00,
    FDM_RUN = 2'b01,
    FDM_JOG = 2'b11,
    FDM_HOLD = 2'b10
  } fdm_mode_t;

  // Share of a value, with the share given in 0.1 percent steps.
  function automatic logic [15:0] pct_of(input logic [15:0] v,
                                         input logic [10:0] p);
    logic [26:0] prod;
    prod = {11'h000, v} * {16'h0000, p};
    pct_of = 16'(prod / PCT_FULL);
  endfunction

  // Moves a frequency inside a jump band onto the nearer band edge.
  function automatic logic [15:0] jump_skip(input logic [15:0] f,
                                            input logic [15:0] j,
                                            input logic [15:0] amp);
    logic [16:0] lo;
    logic [16:0] hi;
    lo = (j > amp) ? {1'b0, j - amp} : 17'h00000;
    hi = {1'b0, j} + {1'b0, amp};
    jump_skip = f;
    if (j != 16'h0000 && {1'b0, f} > lo && {1'b0, f} < hi) begin
      jump_skip = (f < j) ? lo[15:0] : (hi[16] ? 16'hffff : hi[15:0]);
    end
  endfunction
endpackage

// File: core/fdm_level_det.sv
// Hysteretic frequency level detector.
`timescale 1ns/10ps
module fdm_level_det (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [15:0] freq,
  input wire logic [15:0] level,
  input wire logic [9:0] hyst,
  output logic flag
);
  logic flag_q;
  logic flag_d;
  logic [15:0] release_lvl;

  always_comb begin
    release_lvl = level - fdm_pkg::pct_of(level, {1'b0, hyst});
    if (flag_q) begin
      flag_d = (freq >= release_lvl);
    end else begin
      flag_d = (freq >= level);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign flag = flag_q;

  a_level_sets: assert property (@(posedge aclk) disable iff (!aresetn)
    (freq >= level) |=> flag_q)
    else $error("level flag not set at or above level");
  a_hyst_release: assert property (@(posedge aclk) disable iff (!aresetn)
    (freq < release_lvl) |=> !flag_q)
    else $error("level flag held below release level");
endmodule

// File: core/fdm_window_det.sv
// Frequency window detector: flag while within plus or minus a width.
`timescale 1ns/10ps
module fdm_window_det (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [15:0] freq,
  input wire logic [15:0] center,
  input wire logic [15:0] fmax,
  input wire logic [9:0] width,
  output logic flag
);
  logic flag_q;
  logic flag_d;
  logic [15:0] w;
  logic [16:0] lo;
  logic [16:0] hi;

  always_comb begin
    w = fdm_pkg::pct_of(fmax, {1'b0, width});
    lo = (center > w) ? {1'b0, center - w} : 17'h00000;
    hi = {1'b0, center} + {1'b0, w};
    flag_d = ({1'b0, freq} >= lo) && ({1'b0, freq} <= hi);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign flag = flag_q;

  a_window_hit: assert property (@(posedge aclk) disable iff (!aresetn)
    (freq == center) |=> flag_q)
    else $error("window flag low at its center");
endmodule

// File: tb/fdm_terminals.sv
// Model of the output terminal bank and the external run and jog contacts.
`timescale 1ns/10ps
module fdm_terminals (
  input wire logic aclk,
  input wire logic run_close,
  input wire logic jog_close,
  input wire logic [6:0] flags,
  output logic run_cmd_pin,
  output logic jog_cmd_pin,
  output logic [6:0] term_q
);
  // Contacts close at any moment, so the pins move off the clock grid.
  assign #1.3 run_cmd_pin = run_close;
  assign #1.3 jog_cmd_pin = jog_close;
  // The terminal bank latches the function flags once per control cycle.
  always_ff @(posedge aclk) begin
    term_q <= flags;
  end
endmodule

// File: tb/tb.sv
// Self-checking bench of the frequency level monitor.
`timescale 1ns/10ps
module tb;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0] bresp, rresp;
  logic [15:0] run_freq = 16'h0, target_freq = 16'h0bb8, ramp_freq = 16'h0;
  logic [15:0] drive_freq;
  logic ramp_accel = 1'b0, ramp_decel = 1'b0, running = 1'b0;
  logic fault_reset = 1'b0, run_close = 1'b1, jog_close = 1'b0;
  logic [10:0] load_pct = 11'h000;
  logic run_cmd_pin, jog_cmd_pin, run_allow, jog_run, accel_sel2, decel_sel2;
  logic irq;
  logic [6:0] flags, term_q;
  int failures = 0, total_checks = 0;

  fdm_monitor #(.HOUR_CYCLES(10)) u_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .run_freq(run_freq),
    .target_freq(target_freq), .ramp_freq(ramp_freq),
    .ramp_accel(ramp_accel), .ramp_decel(ramp_decel), .running(running),
    .load_pct(load_pct), .fault_reset(fault_reset),
    .run_cmd_pin(run_cmd_pin), .jog_cmd_pin(jog_cmd_pin),
    .out_fn3_level_one(flags[0]), .level_two_flag(flags[1]),
    .out_fn4_reach(flags[2]), .out_fn12_run_time(flags[3]),
    .out_fn24_power_on(flags[4]), .out_fn26_arb_one(flags[5]),
    .out_fn27_arb_two(flags[6]), .run_allow(run_allow), .jog_run(jog_run),
    .accel_sel2(accel_sel2), .decel_sel2(decel_sel2),
    .drive_freq(drive_freq), .irq(irq));

  fdm_terminals u_term (.aclk(aclk), .run_close(run_close),
    .jog_close(jog_close), .flags(flags), .run_cmd_pin(run_cmd_pin),
    .jog_cmd_pin(jog_cmd_pin), .term_q(term_q));

  initial begin
    forever #2 aclk = ~aclk;
  end

  task automatic wrap_up;
    if (failures == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // Ends at the falling edge where the chosen line is seen high: 0 write
  // address, 1 write response, 2 read address, 3 read data.
  task automatic await(input int which);
    logic [3:0] lines;
    int n;
    n = 0;
    do begin
      @(negedge aclk);
      n++;
      lines = {rvalid, arready, bvalid, awready};
    end while (lines[which] !== 1'b1 && n < 200);
    if (lines[which] !== 1'b1) begin
      failures++;
      wrap_up();
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    await(0);
    @(posedge aclk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    // Released lines carry garbage so a stale value cannot pass.
    awaddr <= ~a;
    wdata <= ~d;
    await(1);
    check(32'(bresp), 32'(fdm_pkg::RESP_OKAY));
    // Ready is left high so a following call never drives it twice at once.
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input logic [1:0] resp);
    logic [31:0] d;
    logic [1:0] r;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    await(2);
    @(posedge aclk);
    arvalid <= 1'b0;
    araddr <= ~a;
    await(3);
    d = rdata;
    r = rresp;
    @(posedge aclk);
    check(d, exp);
    check(32'(r), 32'(resp));
  endtask

  task automatic probe(input logic [15:0] f, input logic [6:0] m,
                       input logic [6:0] e);
    run_freq <= f;
    settle(4);
    check(32'(term_q & m), 32'(e));
  endtask

  task automatic ramp(input logic a, input logic d, input logic [15:0] f);
    ramp_accel <= a;
    ramp_decel <= d;
    ramp_freq <= f;
    run_freq <= f;
    settle(4);
  endtask

  task automatic pulse_fault;
    fault_reset <= 1'b1;
    settle(1);
    fault_reset <= 1'b0;
    settle(8);
  endtask

  task automatic reclose;
    run_close <= 1'b0;
    settle(8);
    run_close <= 1'b1;
    settle(8);
  endtask

  initial begin
    settle(6);
    aresetn <= 1'b1;
    settle(1);
    wr(fdm_pkg::OFF_ARRIVE, 32'h0003_0028);
    rd(fdm_pkg::OFF_CTRL, fdm_pkg::RST_CTRL, fdm_pkg::RESP_OKAY);
    rd(fdm_pkg::OFF_LVL1, fdm_pkg::RST_LVL, fdm_pkg::RESP_OKAY);
    rd(fdm_pkg::OFF_LVL2, fdm_pkg::RST_LVL, fdm_pkg::RESP_OKAY);
    rd(8'h3c, 32'h0, fdm_pkg::RESP_SLVERR);
    settle(1);
    check(32'(term_q[4:3]), 32'h0);
    settle(450);
    check(32'(term_q[4]), 32'h1);
    check(32'(run_allow), 32'h0);
    running <= 1'b1;
    settle(45);
    check(32'(term_q[3]), 32'h1);
    reclose();
    check(32'(run_allow), 32'h1);
    pulse_fault();
    check(32'(run_allow), 32'h0);
    reclose();
    check(32'(run_allow), 32'h1);
    wr(fdm_pkg::OFF_CTRL, 32'h0000_0004);
    pulse_fault();
    check(32'(run_allow), 32'h1);
    jog_close <= 1'b1;
    settle(8);
    check(32'(jog_run), 32'h1);
    wr(fdm_pkg::OFF_LVL2, 32'h0064_03e8);
    wr(fdm_pkg::OFF_REACH, 32'h000a_1388);
    wr(fdm_pkg::OFF_ARB2, 32'h0002_0fa0);
    probe(16'h1388, 7'h23, 7'h23);
    probe(16'h128e, 7'h01, 7'h01);
    probe(16'h128d, 7'h21, 7'h00);
    probe(16'h0fab, 7'h40, 7'h00);
    probe(16'h0faa, 7'h40, 7'h40);
    probe(16'h0beb, 7'h04, 7'h00);
    probe(16'h0bea, 7'h04, 7'h04);
    probe(16'h0b86, 7'h06, 7'h06);
    probe(16'h0385, 7'h02, 7'h02);
    probe(16'h0383, 7'h02, 7'h00);
    wr(fdm_pkg::OFF_SWPT, 32'h03e8_07d0);
    ramp(1'b1, 1'b0, 16'h05dc);
    check(32'(accel_sel2), 32'h1);
    ramp(1'b1, 1'b0, 16'h09c4);
    check(32'(accel_sel2), 32'h0);
    ramp(1'b0, 1'b1, 16'h05dc);
    check(32'(decel_sel2), 32'h0);
    ramp(1'b0, 1'b1, 16'h01f4);
    check(32'(decel_sel2), 32'h1);
    wr(fdm_pkg::OFF_JUMP, 32'h0000_0bb8);
    wr(fdm_pkg::OFF_JAMP, 32'h0000_0064);
    wr(fdm_pkg::OFF_CTRL, 32'h0000_0006);
    ramp(1'b1, 1'b0, 16'h0b86);
    check(32'(drive_freq), 32'h0b54);
    ramp(1'b1, 1'b0, 16'h0bb8);
    check(32'(drive_freq), 32'h0c1c);
    wr(fdm_pkg::OFF_CTRL, 32'h0000_0004);
    ramp(1'b1, 1'b0, 16'h0b86);
    check(32'(drive_freq), 32'h0b86);
    wr(fdm_pkg::OFF_JAMP, 32'h0064_0064);
    load_pct <= 11'h3e8;
    ramp(1'b0, 1'b0, 16'h1388);
    check(32'(drive_freq), 32'h1324);
    load_pct <= 11'h1f4;
    settle(4);
    check(32'(drive_freq), 32'h1356);
    wr(fdm_pkg::OFF_IRQ_MASK, 32'h0000_0001);
    settle(2);
    check(32'(irq), 32'h1);
    wr(fdm_pkg::OFF_IRQ_STAT, 32'h0000_003f);
    rd(fdm_pkg::OFF_IRQ_STAT, 32'h0, fdm_pkg::RESP_OKAY);
    check(32'(irq), 32'h0);
    probe(16'h0000, 7'h01, 7'h00);
    probe(16'h1388, 7'h01, 7'h01);
    check(32'(irq), 32'h1);
    wr(fdm_pkg::OFF_IRQ_MASK, 32'h0000_0000);
    settle(2);
    check(32'(irq), 32'h0);
    wrap_up();
  end
endmodule
